// *** design/tfs_consts.svh ***
// Constants for the time-division FIFO memory block
`ifndef TFS_CONSTS_SVH
`define TFS_CONSTS_SVH
`define TFS_WORD_BITS 64
`define TFS_ADDR_BITS 9
`define TFS_DEPTH 432
`define TFS_RX_BASE 9'h000
`define TFS_RX_WORDS 9'h0C0
`define TFS_TXA_BASE 9'h0C0
`define TFS_TXA_WORDS 9'h060
`define TFS_TXB_BASE 9'h120
`define TFS_TXB_WORDS 9'h060
`define TFS_TX1_WORDS 9'h0C0
`define TFS_LIST_BASE 9'h180
`define TFS_LIST_WORDS 9'h010
`define TFS_MIN_FIFO_WORDS 9'h03F
`endif

// *** design/tfs_fifo_mem.sv ***
// Time-division shared FIFO memory with ring pointer sets
`timescale 1ns/10ps
`include "tfs_consts.svh"
// Contract
// - All array reads and writes happen on the single host clock.
// - Access uses fixed time slots, no request or arbitration.
// - Host side owns every other cycle, moving one 64-bit word.
// - Frame engine owns one quarter of cycles through a 64-bit port.
// - Spare quarter may be given to the frame engine.
// - Diagnostic port can read and write the array.
// - Array holds 1.5 KB receive, two 0.75 KB transmit, three lists.
// - Single-channel mode merges both transmit regions into 1.5 KB.
// - Pointers wrap circularly inside each ring region.
// - Both clients take addresses and levels from shared pointer sets.
// - Each channel has its own pointer set; both transmit sets share flush[1], and TXB uses ring 1 in single-channel mode.
// - Every ring holds at least 500 bytes.
module tfs_fifo_mem (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic spare_to_engine,
    input wire logic single_channel,
    input wire logic [1:0] flush,
    input wire tfs_pkg::tfs_ch_t host_ch,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [63:0] host_wdata,
    input wire tfs_pkg::tfs_ch_t eng_ch,
    input wire logic eng_wr,
    input wire logic eng_rd,
    input wire logic [63:0] eng_wdata,
    input wire logic diag_en,
    input wire logic diag_we,
    input wire logic [8:0] diag_addr,
    input wire logic [63:0] diag_wdata,
    output logic host_slot,
    output logic eng_slot,
    output logic host_rvalid,
    output logic [63:0] host_rdata,
    output logic eng_rvalid,
    output logic [63:0] eng_rdata,
    output logic diag_rvalid,
    output logic [63:0] diag_rdata,
    output logic [2:0] full,
    output logic [2:0] empty,
    output logic [8:0] rx_level,
    output logic [8:0] tx_level
);
    import tfs_pkg::*;

    logic [63:0] mem [0:`TFS_DEPTH-1];
    tfs_slot_t slot_reg;
    tfs_slot_t slot_next;
    logic host_go;
    logic eng_go;
    logic diag_go;
    logic acc_we;
    logic [8:0] acc_addr;
    logic [63:0] acc_wdata;
    logic [2:0] push;
    logic [2:0] pop;
    logic [2:0] full_w;
    logic [2:0] empty_w;
    logic [8:0] level_w [0:2];
    logic [8:0] wr_addr_w [0:2];
    logic [8:0] rd_addr_w [0:2];

    tfs_ptr_if ptr [0:2] ();

    function automatic logic [8:0] ring_base(input int idx);
        case (idx)
            0: ring_base = `TFS_RX_BASE;
            1: ring_base = `TFS_TXA_BASE;
            default: ring_base = `TFS_TXB_BASE;
        endcase
    endfunction : ring_base

    function automatic logic [8:0] ring_size(input int idx,
                                             input logic one_ch);
        case (idx)
            0: ring_size = `TFS_RX_WORDS;
            1: ring_size = one_ch ? `TFS_TX1_WORDS : `TFS_TXA_WORDS;
            default: ring_size = `TFS_TXB_WORDS;
        endcase
    endfunction : ring_size

    // Slot sequence: host, engine, host, spare
    always_comb begin
        case (slot_reg)
            TFS_SLOT_HOST_A: slot_next = TFS_SLOT_ENG;
            TFS_SLOT_ENG: slot_next = TFS_SLOT_HOST_B;
            TFS_SLOT_HOST_B: slot_next = TFS_SLOT_SPARE;
            TFS_SLOT_SPARE: slot_next = TFS_SLOT_HOST_A;
            default: slot_next = TFS_SLOT_HOST_A;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            slot_reg <= TFS_SLOT_HOST_A;
        end else begin
            slot_reg <= slot_next;
        end
    end

    logic host_now;
    logic eng_now;
    assign host_now = (slot_reg == TFS_SLOT_HOST_A) ||
                      (slot_reg == TFS_SLOT_HOST_B);
    assign eng_now = (slot_reg == TFS_SLOT_ENG) ||
                     (slot_reg == TFS_SLOT_SPARE && spare_to_engine);

    // Slot flags registered from slot_next so they line up with the current slot
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            host_slot <= 1'b0;
            eng_slot <= 1'b0;
        end else begin
            host_slot <= (slot_next == TFS_SLOT_HOST_A) ||
                         (slot_next == TFS_SLOT_HOST_B);
            eng_slot <= (slot_next == TFS_SLOT_ENG) ||
                        (slot_next == TFS_SLOT_SPARE && spare_to_engine);
        end
    end

    // Merged transmit traffic uses ring 1 only
    function automatic int ring_of(input tfs_ch_t ch, input logic one_ch);
        case (ch)
            TFS_CH_RX: ring_of = 0;
            TFS_CH_TXA: ring_of = 1;
            TFS_CH_TXB: ring_of = one_ch ? 1 : 2;
            default: ring_of = 0;
        endcase
    endfunction : ring_of

    int h_ring;
    int e_ring;
    assign h_ring = ring_of(host_ch, single_channel);
    assign e_ring = ring_of(eng_ch, single_channel);

    assign host_go = host_now && ((host_wr && !full_w[h_ring]) ||
                     (host_rd && !host_wr && !empty_w[h_ring]));
    assign eng_go = eng_now && ((eng_wr && !full_w[e_ring]) ||
                    (eng_rd && !eng_wr && !empty_w[e_ring]));
    // Diagnostics use the spare slot when the engine does not take it
    assign diag_go = diag_en && slot_reg == TFS_SLOT_SPARE &&
                     !spare_to_engine;

    always_comb begin
        push = 3'b000;
        pop = 3'b000;
        acc_we = 1'b0;
        acc_addr = 9'h000;
        acc_wdata = 64'h0000_0000_0000_0000;
        if (host_go) begin
            acc_we = host_wr;
            acc_wdata = host_wdata;
            acc_addr = host_wr ? wr_addr_w[h_ring] : rd_addr_w[h_ring];
            push[h_ring] = host_wr;
            pop[h_ring] = !host_wr;
        end else if (eng_go) begin
            acc_we = eng_wr;
            acc_wdata = eng_wdata;
            acc_addr = eng_wr ? wr_addr_w[e_ring] : rd_addr_w[e_ring];
            push[e_ring] = eng_wr;
            pop[e_ring] = !eng_wr;
        end else if (diag_go) begin
            acc_we = diag_we;
            acc_wdata = diag_wdata;
            acc_addr = diag_addr;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_ring
            assign ptr[gi].push = push[gi];
            assign ptr[gi].pop = pop[gi];
            assign ptr[gi].flush = gi == 0 ? flush[0] : flush[1];
            assign ptr[gi].base = ring_base(gi);
            assign ptr[gi].size = ring_size(gi, single_channel);
            assign wr_addr_w[gi] = ptr[gi].wr_addr;
            assign rd_addr_w[gi] = ptr[gi].rd_addr;
            assign level_w[gi] = ptr[gi].level;
            assign full_w[gi] = ptr[gi].full;
            assign empty_w[gi] = ptr[gi].empty;
            tfs_ring_ptr u_ring (
                .clock(clock),
                .sys_rst(sys_rst),
                .p(ptr[gi])
            );
        end
    endgenerate

    // Single-port array, one access per clock
    logic [63:0] rd_word;
    always_ff @(posedge clock) begin
        if (acc_we && acc_addr < 9'(`TFS_DEPTH)) begin
            mem[acc_addr] <= acc_wdata;
        end
    end
    assign rd_word = (acc_addr < 9'(`TFS_DEPTH)) ? mem[acc_addr] :
                     64'h0000_0000_0000_0000;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            host_rvalid <= 1'b0;
            eng_rvalid <= 1'b0;
            diag_rvalid <= 1'b0;
            host_rdata <= 64'h0000_0000_0000_0000;
            eng_rdata <= 64'h0000_0000_0000_0000;
            diag_rdata <= 64'h0000_0000_0000_0000;
        end else begin
            host_rvalid <= host_go && !host_wr;
            eng_rvalid <= eng_go && !eng_wr;
            diag_rvalid <= diag_go && !diag_we;
            if (host_go && !host_wr) begin
                host_rdata <= rd_word;
            end
            if (eng_go && !eng_wr) begin
                eng_rdata <= rd_word;
            end
            if (diag_go && !diag_we) begin
                diag_rdata <= rd_word;
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            full <= 3'b000;
            empty <= 3'b111;
            rx_level <= 9'h000;
            tx_level <= 9'h000;
        end else begin
            full <= full_w;
            empty <= empty_w;
            rx_level <= level_w[0];
            tx_level <= level_w[1];
        end
    end

    // Checks
    property p_host_alt;
        @(posedge clock) disable iff (sys_rst)
        host_now |=> !host_now ##1 host_now;
    endproperty
    a_host_alt: assert property (p_host_alt)
        else $error("host slot not alternate");
    // The flag leaves reset one cycle late, so skip the first edge
    property p_host_flag;
        @(posedge clock) disable iff (sys_rst)
        !$past(sys_rst) |-> host_slot == host_now;
    endproperty
    a_host_flag: assert property (p_host_flag)
        else $error("host slot flag out of step");
    property p_eng_quarter;
        @(posedge clock) disable iff (sys_rst)
        slot_reg == TFS_SLOT_ENG |-> ##4 slot_reg == TFS_SLOT_ENG;
    endproperty
    a_eng_quarter: assert property (p_eng_quarter)
        else $error("engine slot period");
    property p_order;
        @(posedge clock) disable iff (sys_rst)
        slot_reg == TFS_SLOT_HOST_A |=> slot_reg == TFS_SLOT_ENG ##1
        slot_reg == TFS_SLOT_HOST_B ##1 slot_reg == TFS_SLOT_SPARE;
    endproperty
    a_order: assert property (p_order)
        else $error("slot order broken");
    property p_spare;
        @(posedge clock) disable iff (sys_rst)
        slot_reg == TFS_SLOT_SPARE && $past(spare_to_engine) |-> eng_slot;
    endproperty
    a_spare: assert property (p_spare)
        else $error("spare not given");
    property p_no_over;
        @(posedge clock) disable iff (sys_rst)
        full_w[0] && !pop[0] && !flush[0] |=> $stable(level_w[0]);
    endproperty
    a_no_over: assert property (p_no_over)
        else $error("rx overfilled");
    property p_no_under;
        @(posedge clock) disable iff (sys_rst)
        empty_w[0] && !push[0] && !flush[0] |=> $stable(rd_addr_w[0]);
    endproperty
    a_no_under: assert property (p_no_under)
        else $error("rx underflow");
    property p_rdv;
        @(posedge clock) disable iff (sys_rst)
        host_go && !host_wr |=> host_rvalid ##1 !host_rvalid;
    endproperty
    a_rdv: assert property (p_rdv)
        else $error("host read valid");
    property p_wrap;
        @(posedge clock) disable iff (sys_rst)
        wr_addr_w[0] < `TFS_RX_WORDS;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("rx pointer escaped");
    property p_min;
        @(posedge clock) disable iff (sys_rst)
        ptr[0].size >= `TFS_MIN_FIFO_WORDS &&
        ptr[1].size >= `TFS_MIN_FIFO_WORDS &&
        ptr[2].size >= `TFS_MIN_FIFO_WORDS;
    endproperty
    a_min: assert property (p_min)
        else $error("ring under 500 bytes");
    c_host_rd: cover property (@(posedge clock) host_rvalid);
    c_eng_wr: cover property (@(posedge clock) eng_go && eng_wr);
    c_rx_full: cover property (@(posedge clock) full_w[0]);
    c_diag: cover property (@(posedge clock) diag_rvalid);
    c_spare_eng: cover property (@(posedge clock)
        eng_go && slot_reg == TFS_SLOT_SPARE);
endmodule : tfs_fifo_mem

// *** design/tfs_pkg.sv ***
// Types shared by the time-division FIFO memory block
package tfs_pkg;
    typedef enum logic [1:0] {
        TFS_SLOT_HOST_A = 2'b00,
        TFS_SLOT_ENG = 2'b01,
        TFS_SLOT_HOST_B = 2'b11,
        TFS_SLOT_SPARE = 2'b10
    } tfs_slot_t;
    typedef enum logic [1:0] {
        TFS_CH_RX = 2'h0,
        TFS_CH_TXA = 2'h1,
        TFS_CH_TXB = 2'h2
    } tfs_ch_t;
endpackage : tfs_pkg

// *** design/tfs_ptr_if.sv ***
// Pointer set signals between the scheduler and one ring pointer set
`timescale 1ns/10ps
interface tfs_ptr_if;
    logic push;
    logic pop;
    logic flush;
    logic [8:0] base;
    logic [8:0] size;
    logic [8:0] wr_addr;
    logic [8:0] rd_addr;
    logic [8:0] level;
    logic full;
    logic empty;
    modport ctrl (output push, pop, flush, base, size,
                  input wr_addr, rd_addr, level, full, empty);
    modport ring (input push, pop, flush, base, size,
                  output wr_addr, rd_addr, level, full, empty);
endinterface : tfs_ptr_if

// *** design/tfs_ring_ptr.sv ***
// One ring FIFO pointer and counter set
`timescale 1ns/10ps
`include "tfs_consts.svh"
module tfs_ring_ptr (
    input wire logic clock,
    input wire logic sys_rst,
    tfs_ptr_if.ring p
);
    logic [8:0] wr_off_reg;
    logic [8:0] rd_off_reg;
    logic [8:0] level_reg;
    logic do_push;
    logic do_pop;

    function automatic logic [8:0] wrap_inc(input logic [8:0] off,
                                            input logic [8:0] size);
        wrap_inc = (off == size - 9'h001) ? 9'h000 : off + 9'h001;
    endfunction : wrap_inc

    assign do_push = p.push && (level_reg != p.size);
    assign do_pop = p.pop && (level_reg != 9'h000);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wr_off_reg <= 9'h000;
            rd_off_reg <= 9'h000;
        end else if (p.flush) begin
            wr_off_reg <= 9'h000;
            rd_off_reg <= 9'h000;
        end else begin
            if (do_push) begin
                wr_off_reg <= wrap_inc(wr_off_reg, p.size);
            end
            if (do_pop) begin
                rd_off_reg <= wrap_inc(rd_off_reg, p.size);
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            level_reg <= 9'h000;
        end else if (p.flush) begin
            level_reg <= 9'h000;
        end else if (do_push && !do_pop) begin
            level_reg <= level_reg + 9'h001;
        end else if (do_pop && !do_push) begin
            level_reg <= level_reg - 9'h001;
        end
    end

    assign p.wr_addr = p.base + wr_off_reg;
    assign p.rd_addr = p.base + rd_off_reg;
    assign p.level = level_reg;
    assign p.full = (level_reg == p.size);
    assign p.empty = (level_reg == 9'h000);
endmodule : tfs_ring_ptr

// *** sim/testbench.sv ***
// Self-checking bench for the time-division FIFO memory
`timescale 1ns/10ps
`include "tfs_consts.svh"
module testbench;
    import tfs_pkg::*;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic spare_to_engine = 1'b0;
    logic single_channel = 1'b0;
    logic [1:0] flush = 2'h0;
    tfs_ch_t host_ch = TFS_CH_RX;
    logic host_wr = 1'b0;
    logic host_rd = 1'b0;
    logic [63:0] host_wdata = 64'h0;
    logic diag_en = 1'b0;
    logic diag_we = 1'b0;
    logic [8:0] diag_addr = 9'h000;
    logic [63:0] diag_wdata = 64'h0;
    logic wr_run = 1'b0;
    logic rd_run = 1'b0;
    tfs_ch_t eng_ch;
    logic eng_wr, eng_rd, host_slot, eng_slot, host_rvalid, eng_rvalid;
    logic diag_rvalid;
    logic [63:0] eng_wdata, host_rdata, eng_rdata, diag_rdata;
    logic [2:0] full, empty;
    logic [8:0] rx_level, tx_level;
    int failures = 0;
    int n_tests = 0;

    tfs_fifo_mem u_dut (.clock, .sys_rst, .spare_to_engine, .single_channel,
        .flush, .host_ch, .host_wr, .host_rd, .host_wdata, .eng_ch, .eng_wr,
        .eng_rd, .eng_wdata, .diag_en, .diag_we, .diag_addr, .diag_wdata,
        .host_slot, .eng_slot, .host_rvalid, .host_rdata, .eng_rvalid,
        .eng_rdata, .diag_rvalid, .diag_rdata, .full, .empty, .rx_level,
        .tx_level);
    tfs_eng_model u_eng (.clock, .wr_run, .rd_run, .eng_slot, .rx_level,
        .empty, .eng_ch, .eng_wr, .eng_rd, .eng_wdata);

    initial begin
        forever #4 clock = ~clock;
    end

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input bit ok, input string msg);
        n_tests++;
        if (!ok) begin
            failures++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask : chk

    task automatic give_up(input string msg);
        chk(1'b0, msg);
        print_verdict();
    endtask : give_up

    function automatic logic [63:0] pat(input logic [15:0] t, input int i);
        return {t, 32'h0000_0000, 16'(i)};
    endfunction : pat

    // One host access in the next host slot; entered at a falling edge
    task automatic host_op(input tfs_ch_t ch, input logic wr,
                           input logic [63:0] wd, output logic got,
                           output logic [63:0] rd);
        int n = 0;
        while (host_slot !== 1'b1) begin
            @(negedge clock);
            n++;
            if (n > 8) give_up("no host slot");
        end
        host_ch = ch;
        host_wr = wr;
        host_rd = ~wr;
        host_wdata = wd;
        @(negedge clock);
        host_wr = 1'b0;
        host_rd = 1'b0;
        got = host_rvalid;
        rd = host_rdata;
    endtask : host_op

    // Diagnostic access in the next idle spare slot
    task automatic diag_op(input logic we, input logic [8:0] a,
                           input logic [63:0] wd, output logic got,
                           output logic [63:0] rd);
        int n = 0;
        while (host_slot !== 1'b0 || eng_slot !== 1'b0) begin
            @(negedge clock);
            n++;
            if (n > 8) give_up("no spare slot");
        end
        diag_en = 1'b1;
        diag_we = we;
        diag_addr = a;
        diag_wdata = wd;
        @(negedge clock);
        diag_en = 1'b0;
        diag_we = 1'b0;
        got = diag_rvalid;
        rd = diag_rdata;
    endtask : diag_op

    task automatic wait_rx(input logic [8:0] lvl);
        int n = 0;
        while (rx_level !== lvl) begin
            @(negedge clock);
            n++;
            if (n > 1000) give_up("rx level not reached");
        end
    endtask : wait_rx

    task automatic t_reset();
        chk(host_slot === 1'b0 && eng_slot === 1'b0, "slots in reset");
        chk(empty === 3'b111 && full === 3'b000, "flags in reset");
        chk(rx_level === 9'h000 && tx_level === 9'h000, "levels");
    endtask : t_reset

    task automatic t_slots();
        for (int k = 0; k < 8; k++) begin
            @(negedge clock);
            chk(host_slot === (k % 2 == 1), "host slot order");
            chk(eng_slot === (k % 4 == 0), "engine slot order");
        end
        spare_to_engine = 1'b1;
        @(negedge clock);
        for (int k = 0; k < 8; k++) begin
            @(negedge clock);
            chk(eng_slot === ~host_slot, "spare to engine");
        end
        spare_to_engine = 1'b0;
        @(negedge clock);
    endtask : t_slots

    task automatic t_rx();
        logic got;
        logic [63:0] d;
        wr_run <= 1'b1;
        wait_rx(`TFS_RX_WORDS);
        repeat (8) @(negedge clock);
        chk(rx_level === `TFS_RX_WORDS, "rx overfilled");
        chk(full[0] === 1'b1, "rx full flag");
        wr_run <= 1'b0;
        for (int i = 0; i < 192; i++) begin
            host_op(TFS_CH_RX, 1'b0, 64'h0, got, d);
            chk(got === 1'b1 && d === pat(16'hA5A5, i), "rx data");
        end
        @(negedge clock);
        chk(empty[0] === 1'b1 && rx_level === 9'h000, "rx empty");
        host_op(TFS_CH_RX, 1'b0, 64'h0, got, d);
        chk(got === 1'b0, "read of empty ring answered");
        wr_run <= 1'b1;
        wait_rx(9'h008);
        wr_run <= 1'b0;
    endtask : t_rx

    task automatic t_tx();
        logic got;
        logic [63:0] d;
        int n = 0;
        int c = 0;
        for (int i = 0; i < 97; i++) begin
            host_op(TFS_CH_TXA, 1'b1, pat(16'h7E7E, i), got, d);
        end
        @(negedge clock);
        chk(tx_level === `TFS_TXA_WORDS && full[1] === 1'b1, "txa");
        chk(rx_level === 9'h008, "rx ring disturbed");
        rd_run <= 1'b1;
        spare_to_engine = 1'b1;
        while (n < 96 && c < 1000) begin
            @(negedge clock);
            c++;
            if (eng_rvalid === 1'b1) begin
                chk(eng_rdata === pat(16'h7E7E, n), "engine data");
                n++;
            end
        end
        rd_run <= 1'b0;
        spare_to_engine = 1'b0;
        chk(n == 96, "engine reads missing");
        chk(c <= 200, "spare slots not used");
        @(negedge clock);
        chk(empty[1] === 1'b1 && tx_level === 9'h000, "txa empty");
        for (int i = 192; i < 200; i++) begin
            host_op(TFS_CH_RX, 1'b0, 64'h0, got, d);
            chk(got === 1'b1 && d === pat(16'hA5A5, i), "rx wrap");
        end
    endtask : t_tx

    task automatic t_single();
        logic got;
        logic [63:0] d;
        host_op(TFS_CH_TXB, 1'b1, pat(16'h2B2B, 0), got, d);
        host_op(TFS_CH_RX, 1'b1, pat(16'h2B2B, 1), got, d);
        @(negedge clock);
        chk(empty === 3'b010 && rx_level === 9'h001, "rings apart");
        single_channel = 1'b1;
        @(negedge clock);
        for (int i = 0; i < 193; i++) begin
            host_op(TFS_CH_TXB, 1'b1, pat(16'h5151, i), got, d);
        end
        @(negedge clock);
        chk(tx_level === `TFS_TX1_WORDS, "merged tx ring size");
        flush = 2'b11;
        @(negedge clock);
        flush = 2'b00;
        @(negedge clock);
        chk(tx_level === 9'h000 && empty === 3'b111, "tx flush");
        chk(rx_level === 9'h000, "rx flush");
        single_channel = 1'b0;
    endtask : t_single

    task automatic t_diag();
        logic got;
        logic [63:0] d;
        diag_op(1'b1, `TFS_LIST_BASE, 64'hD1A6_0000_0000_0180, got, d);
        diag_op(1'b1, 9'h1AF, 64'hD1A6_0000_0000_01AF, got, d);
        diag_op(1'b0, `TFS_LIST_BASE, 64'h0, got, d);
        chk(got === 1'b1 && d === 64'hD1A6_0000_0000_0180, "list");
        diag_op(1'b0, 9'h1AF, 64'h0, got, d);
        chk(got === 1'b1 && d === 64'hD1A6_0000_0000_01AF, "top");
    endtask : t_diag

    initial begin
        repeat (16) @(negedge clock);
        t_reset();
        sys_rst = 1'b0;
        t_slots();
        t_rx();
        t_tx();
        t_single();
        t_diag();
        print_verdict();
    end
endmodule : testbench

// *** sim/tfs_eng_model.sv ***
// Frame engine model: fills the receive ring and drains transmit ring A
`timescale 1ns/10ps
`include "tfs_consts.svh"
module tfs_eng_model (
    input wire logic clock,
    input wire logic wr_run,
    input wire logic rd_run,
    input wire logic eng_slot,
    input wire logic [8:0] rx_level,
    input wire logic [2:0] empty,
    output tfs_pkg::tfs_ch_t eng_ch,
    output logic eng_wr,
    output logic eng_rd,
    output logic [63:0] eng_wdata
);
    import tfs_pkg::*;
    logic [15:0] idx = 16'h0000;
    initial begin
        eng_ch = TFS_CH_RX;
        eng_wr = 1'b0;
        eng_rd = 1'b0;
        eng_wdata = 64'h0;
    end
    // Data lines toggle while no write is offered
    always @(negedge clock) begin
        if (eng_slot === 1'b1 && wr_run &&
            rx_level < `TFS_RX_WORDS) begin
            eng_ch <= TFS_CH_RX;
            eng_wr <= 1'b1;
            eng_rd <= 1'b0;
            eng_wdata <= {48'hA5A5_0000_0000, idx};
            idx <= idx + 16'h0001;
        end else if (eng_slot === 1'b1 && rd_run &&
                     empty[1] === 1'b0) begin
            eng_ch <= TFS_CH_TXA;
            eng_wr <= 1'b0;
            eng_rd <= 1'b1;
            eng_wdata <= ~eng_wdata;
        end else begin
            eng_wr <= 1'b0;
            eng_rd <= 1'b0;
            eng_wdata <= ~eng_wdata;
        end
    end
endmodule : tfs_eng_model
